// file: ssp_top.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ssp_cfg.svh"
// Summary of operation
// - ack flag set at eighth fall with holds
// - ack flag clears at ninth rise
// - stop interrupt when enabled, mode allowed
// - start interrupt when enabled, mode allowed
// - spi overwrite loads every byte
// - spi no overwrite: overflow, buffer kept
// - overflow still flagged during overwrite
// - i2c overwrite loads despite overflow
// - i2c no overwrite: loads only while overflow clear
// - sda hold after scl fall: 300/100ns
// - slave collision detect when enabled
// - address hold releases clock control low
// - data hold releases clock control low
// - divider period (n+1)*4 cycles, 3..255
// - ten-bit high byte uses bits 2:1
// - ten-bit low byte uses bits 7:0
// - seven-bit address in bits 7:1
// - mask bit one compares, zero ignores
// - mask bit 0 only in ten-bit
// - mode codes for i2c slave variants
// - clock release zero holds scl low
module ssp_top
  import ssp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`SSP_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SSP_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic spi_rx_valid,
  input wire logic [7:0] spi_rx_byte,
  output logic master_clk_o,
  output logic serial_irq
);
  logic [7:0] buf_r;
  logic [7:0] add_r;
  logic [7:0] msk_r;
  logic [3:0] mode_r;
  logic ckp_r;
  logic [6:0] c3_r;
  logic ack_r;
  logic bf_r;
  logic ov_r;
  logic coll_r;
  ssp_sl_t state_r;
  logic lo_pend_r;
  logic hi_ok_r;
  logic [7:0] tx_r;
  logic drv_r;
  logic [7:0] hold_r;
  logic [7:0] since_r;
  logic irq_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [11:0] widx;
  logic [11:0] ridx;
  logic wr_go;
  logic wen;
  logic rd_go;
  logic w_buf;
  logic w_add;
  logic w_msk;
  logic w_c1;
  logic w_st;
  logic w_c3;
  logic [7:0] rd_mux;
  logic i2c_sl;
  logic i2c_ms;
  logic spi;
  logic ten;
  logic ss_excl;
  logic ss_auto;
  logic m7;
  logic m10hi;
  logic m10lo;
  logic acc;
  logic ack_nxt;
  ssp_sl_t st_nxt;
  logic lo_nxt;
  logic hi_nxt;
  logic coll_evt;
  logic spi_byte;
  logic i2c_byte;
  logic new_b;
  logic load;
  logic [7:0] new_d;
  logic [7:0] hold_cyc;
  logic start_irq;
  logic stop_irq;

  ssp_evt_if ev ();

  ssp_scl_watch u_watch (
    .aclk(aclk),
    .aresetn(aresetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ev(ev)
  );

  ssp_baud_div #(.W(8)) u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(mode_r == SSP_I2C_MST || mode_r == SSP_SPI_MDIV),
    .divisor(add_r),
    .clk_o(master_clk_o)
  );

  function automatic logic idx_ok(input logic [11:0] i);
    return i inside {`SSP_IDX_BUF, `SSP_IDX_ADD, `SSP_IDX_MSK, `SSP_IDX_CTL1, `SSP_IDX_STAT, `SSP_IDX_CTL3};
  endfunction

  // register bus: write takes address and data together
  assign widx = s_axi_awaddr[`SSP_AXI_AW-1:2];
  assign ridx = s_axi_araddr[`SSP_AXI_AW-1:2];
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign wen = wr_go & s_axi_wstrb[0];
  assign w_buf = wen & (widx == `SSP_IDX_BUF);
  assign w_add = wen & (widx == `SSP_IDX_ADD);
  assign w_msk = wen & (widx == `SSP_IDX_MSK);
  assign w_c1 = wen & (widx == `SSP_IDX_CTL1);
  assign w_st = wen & (widx == `SSP_IDX_STAT);
  assign w_c3 = wen & (widx == `SSP_IDX_CTL3);
  assign rd_go = s_axi_arvalid & ~rvalid_r;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_comb begin
    case (ridx)
      `SSP_IDX_BUF: rd_mux = buf_r;
      `SSP_IDX_ADD: rd_mux = add_r;
      `SSP_IDX_MSK: rd_mux = msk_r;
      `SSP_IDX_CTL1: rd_mux = {3'h0, ckp_r, mode_r};
      `SSP_IDX_STAT: rd_mux = {5'h00, coll_r, ov_r, bf_r};
      `SSP_IDX_CTL3: rd_mux = {ack_r, c3_r};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `SSP_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= idx_ok(widx) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `SSP_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_mux};
      rresp_r <= idx_ok(ridx) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      add_r <= `SSP_RST_ADD;
      msk_r <= `SSP_RST_MSK;
      mode_r <= `SSP_RST_MODE;
      c3_r <= `SSP_RST_CTL3;
    end else begin
      if (w_add) add_r <= s_axi_wdata[7:0];
      if (w_msk) msk_r <= s_axi_wdata[7:0];
      if (w_c1) mode_r <= s_axi_wdata[3:0];
      if (w_c3) c3_r <= s_axi_wdata[6:0];
    end
  end

  // mode decode
  assign i2c_sl = &mode_r[2:1];
  assign ten = i2c_sl & mode_r[0];
  assign i2c_ms = (mode_r == SSP_I2C_MST) | (mode_r == SSP_I2C_FW);
  assign spi = ~i2c_sl & ~i2c_ms;
  assign ss_excl = (mode_r == SSP_I2C_S10_SS) | (mode_r == SSP_I2C_S10);
  assign ss_auto = (mode_r == SSP_I2C_S10_SS) | (mode_r == SSP_I2C_S7_SS);

  assign start_irq = ev.start & ((c3_r[`SSP_C3_START_IRQ_ENABLE] & ~spi & ~ss_excl) | ss_auto);
  assign stop_irq = ev.stop & ((c3_r[`SSP_C3_PCIE] & ~spi & ~ss_excl) | ss_auto);

  always_ff @(posedge aclk) begin
    if (!aresetn) irq_r <= 1'b0;
    else irq_r <= start_irq | stop_irq;
  end
  assign serial_irq = irq_r;

  // address comparison
  assign m7 = ((ev.byte_q ^ add_r) & {msk_r[7:1], 1'b0}) == 8'h00;
  assign m10lo = ((ev.byte_q ^ add_r) & msk_r) == 8'h00;
  assign m10hi = (ev.byte_q[7:3] == `SSP_TEN_HDR) & (ev.byte_q[2:1] == add_r[2:1]);

  always_comb begin
    acc = 1'b0;
    st_nxt = SL_IDLE;
    lo_nxt = 1'b0;
    hi_nxt = hi_ok_r;
    if (!ten) begin
      acc = m7;
      st_nxt = m7 ? (ev.byte_q[0] ? SL_TX : SL_RX) : SL_IDLE;
    end else if (lo_pend_r) begin
      acc = m10lo;
      st_nxt = m10lo ? SL_RX : SL_IDLE;
      hi_nxt = m10lo;
    end else if (m10hi && ev.byte_q[0]) begin
      acc = hi_ok_r;
      st_nxt = hi_ok_r ? SL_TX : SL_IDLE;
    end else if (m10hi) begin
      acc = 1'b1;
      st_nxt = SL_ADDR;
      lo_nxt = 1'b1;
    end
  end

  always_comb begin
    unique case (state_r)
      SL_ADDR: ack_nxt = acc;
      SL_RX: ack_nxt = 1'b1;
      SL_TX: ack_nxt = 1'b0;
      SL_IDLE: ack_nxt = 1'b0;
    endcase
  end

  // released line read low while we send means another driver
  assign coll_evt = i2c_sl & c3_r[`SSP_C3_SLAVE_COLLISION_DETECT_ENABLE] & ev.scl_rise & ~ev.rise9 & (state_r == SL_TX) & ~sda_oe & ~sda_i;

  always_ff @(posedge aclk) begin
    if (!aresetn || !i2c_sl || ev.stop) begin
      state_r <= SL_IDLE;
      lo_pend_r <= 1'b0;
      hi_ok_r <= 1'b0;
    end else if (ev.start) begin
      state_r <= SL_ADDR;
      lo_pend_r <= 1'b0;
    end else if (coll_evt) begin
      state_r <= SL_IDLE;
    end else if (ev.fall8 && state_r == SL_ADDR) begin
      state_r <= st_nxt;
      lo_pend_r <= lo_nxt;
      hi_ok_r <= hi_nxt;
    end else if (ev.rise9 && state_r == SL_TX && sda_i) begin
      state_r <= SL_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !i2c_sl || ev.start || ev.stop || coll_evt) begin
      drv_r <= 1'b0;
    end else if (ev.fall8) begin
      drv_r <= ack_nxt;
    end else if (ev.ack_end) begin
      drv_r <= (state_r == SL_TX) & ~buf_r[7];
    end else if (ev.scl_fall && state_r == SL_TX) begin
      drv_r <= ~tx_r[6];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_r <= 8'h00;
    end else if (ev.ack_end && state_r == SL_TX) begin
      tx_r <= buf_r;
    end else if (ev.scl_fall && state_r == SL_TX) begin
      tx_r <= {tx_r[6:0], 1'b1};
    end
  end

  // sda follows the drive request only after the hold time
  assign hold_cyc = c3_r[`SSP_C3_SDA_HOLD_SELECT] ? 8'(`SSP_HOLD_LONG_CYC) : 8'(`SSP_HOLD_SHORT_CYC);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r <= 8'h00;
      sda_oe <= 1'b0;
    end else begin
      if (ev.scl_fall) hold_r <= hold_cyc;
      else if (hold_r != 8'h00) hold_r <= hold_r - 8'h01;
      if (hold_r == 8'h00) sda_oe <= drv_r;
    end
  end
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;

  always_ff @(posedge aclk) begin
    if (!aresetn) since_r <= 8'hff;
    else if (ev.scl_fall) since_r <= 8'h00;
    else if (since_r != 8'hff) since_r <= since_r + 8'h01;
  end

  // acknowledge time flag
  always_ff @(posedge aclk) begin
    if (!aresetn || !i2c_sl) begin
      ack_r <= 1'b0;
    end else if (ev.fall8 && (c3_r[`SSP_C3_ADDRESS_HOLD_ENABLE] || c3_r[`SSP_C3_DATA_HOLD_ENABLE])) begin
      ack_r <= 1'b1;
    end else if (ev.rise9) begin
      ack_r <= 1'b0;
    end
  end

  // hardware stretch has priority over a software release in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ckp_r <= `SSP_RST_CKP;
    end else if (i2c_sl && ev.fall8 && state_r == SL_ADDR && acc && c3_r[`SSP_C3_ADDRESS_HOLD_ENABLE]) begin
      ckp_r <= 1'b0;
    end else if (i2c_sl && ev.fall8 && state_r == SL_RX && c3_r[`SSP_C3_DATA_HOLD_ENABLE]) begin
      ckp_r <= 1'b0;
    end else if (w_c1) begin
      ckp_r <= s_axi_wdata[`SSP_C1_CKP];
    end
  end
  assign scl_oe = i2c_sl & ~ckp_r;

  // receive buffer
  assign spi_byte = spi & spi_rx_valid;
  assign i2c_byte = i2c_sl & ev.fall8 & ((state_r == SL_RX) | ((state_r == SL_ADDR) & acc));
  assign new_b = spi_byte | i2c_byte;
  assign new_d = spi_byte ? spi_rx_byte : ev.byte_q;
  assign load = new_b & (c3_r[`SSP_C3_BUFFER_OVERWRITE_ENABLE] | (spi ? ~bf_r : ~ov_r));

  always_ff @(posedge aclk) begin
    if (!aresetn) buf_r <= `SSP_RST_BUF;
    else if (load) buf_r <= new_d;
    else if (w_buf) buf_r <= s_axi_wdata[7:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bf_r <= 1'b0;
      ov_r <= 1'b0;
      coll_r <= 1'b0;
    end else begin
      bf_r <= load | (bf_r & ~(rd_go & ridx == `SSP_IDX_BUF));
      ov_r <= (new_b & bf_r) | (ov_r & ~(w_st & s_axi_wdata[`SSP_ST_OV]));
      coll_r <= coll_evt | (coll_r & ~(w_st & s_axi_wdata[`SSP_ST_COLL]));
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_hold_byte;
    i2c_sl && ev.fall8 && (c3_r[`SSP_C3_ADDRESS_HOLD_ENABLE] || c3_r[`SSP_C3_DATA_HOLD_ENABLE]);
  endsequence
  sequence s_addr_hold;
    i2c_sl && ev.fall8 && state_r == SL_ADDR && acc && c3_r[`SSP_C3_ADDRESS_HOLD_ENABLE];
  endsequence

  chk_ack_set: assert property (s_hold_byte |=> ack_r)
    else $error("ack phase flag not set");
  chk_ack_clear: assert property ((ev.rise9 || !i2c_sl) |=> !ack_r)
    else $error("ack phase flag not cleared");
  chk_stop_irq: assert property ((ev.stop && c3_r[`SSP_C3_PCIE] && !spi && !ss_excl) |=> serial_irq)
    else $error("stop interrupt missing");
  chk_start_irq: assert property ((ev.start && c3_r[`SSP_C3_START_IRQ_ENABLE] && !spi && !ss_excl) |=> serial_irq)
    else $error("start interrupt missing");
  chk_start_quiet: assert property ((ev.start && !ss_auto && (spi || ss_excl || !c3_r[`SSP_C3_START_IRQ_ENABLE])) |=> !serial_irq)
    else $error("start interrupt while disabled");
  chk_spi_overwrite: assert property ((spi_byte && c3_r[`SSP_C3_BUFFER_OVERWRITE_ENABLE]) |=> buf_r == $past(spi_rx_byte))
    else $error("spi overwrite did not load");
  chk_spi_keep: assert property ((spi_byte && !c3_r[`SSP_C3_BUFFER_OVERWRITE_ENABLE] && bf_r && !w_buf) |=> $stable(buf_r) && ov_r)
    else $error("spi byte overwrote full buffer");
  chk_ovf_buffer_overwrite_enable: assert property ((new_b && bf_r && c3_r[`SSP_C3_BUFFER_OVERWRITE_ENABLE]) |=> ov_r ##1 ov_r || $past(w_st))
    else $error("overflow not flagged");
  chk_i2c_overwrite: assert property ((i2c_byte && c3_r[`SSP_C3_BUFFER_OVERWRITE_ENABLE]) |=> buf_r == $past(ev.byte_q))
    else $error("i2c overwrite did not load");
  chk_i2c_keep: assert property ((i2c_byte && !c3_r[`SSP_C3_BUFFER_OVERWRITE_ENABLE] && ov_r && !w_buf) |=> $stable(buf_r))
    else $error("i2c loaded during overflow");
  chk_sda_hold: assert property ((i2c_sl && $changed(sda_oe)) |-> since_r > $past(hold_cyc))
    else $error("sda changed inside hold time");
  chk_coll_flag: assert property (coll_evt |=> coll_r && state_r == SL_IDLE)
    else $error("collision not caught");
  chk_addr_hold: assert property (s_addr_hold |=> !ckp_r && scl_oe)
    else $error("address hold did not stretch");
  chk_data_hold: assert property ((i2c_sl && ev.fall8 && state_r == SL_RX && c3_r[`SSP_C3_DATA_HOLD_ENABLE]) |=> !ckp_r)
    else $error("data hold did not stretch");
  chk_scl_level: assert property ($rose(scl_oe) |-> $past(ev.fall8) || $past(w_c1))
    else $error("scl stretch without cause");
  chk_match7: assert property ((i2c_sl && !ten && ev.fall8 && state_r == SL_ADDR && !ev.start)
    |=> drv_r == ((ev.byte_q[7:1] & msk_r[7:1]) == (add_r[7:1] & msk_r[7:1])))
    else $error("seven-bit match wrong");
endmodule

// file: ssp_cfg.svh
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_AXI_AW 14
`define SSP_IDX_BUF 12'hf91
`define SSP_IDX_ADD 12'hf92
`define SSP_IDX_MSK 12'hf93
`define SSP_IDX_CTL1 12'hf94
`define SSP_IDX_STAT 12'hf95
`define SSP_IDX_CTL3 12'hf97
`define SSP_RST_BUF 8'h00
`define SSP_RST_ADD 8'h00
`define SSP_RST_MSK 8'hff
`define SSP_RST_CTL3 7'h00
`define SSP_RST_MODE 4'h0
`define SSP_RST_CKP 1'b1
`define SSP_C3_PCIE 6
`define SSP_C3_START_IRQ_ENABLE 5
`define SSP_C3_BUFFER_OVERWRITE_ENABLE 4
`define SSP_C3_SDA_HOLD_SELECT 3
`define SSP_C3_SLAVE_COLLISION_DETECT_ENABLE 2
`define SSP_C3_ADDRESS_HOLD_ENABLE 1
`define SSP_C3_DATA_HOLD_ENABLE 0
`define SSP_C1_CKP 4
`define SSP_ST_BF 0
`define SSP_ST_OV 1
`define SSP_ST_COLL 2
`define SSP_TEN_HDR 5'h1e
`define SSP_RESP_OKAY 2'h0
`define SSP_RESP_SLVERR 2'h2
`define SSP_CLK_NS 10
`define SSP_HOLD_LONG_NS 300
`define SSP_HOLD_SHORT_NS 100
`define SSP_HOLD_LONG_CYC ((`SSP_HOLD_LONG_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`define SSP_HOLD_SHORT_CYC ((`SSP_HOLD_SHORT_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`define SSP_BAUD_MIN 3
`endif

// file: ssp_pkg.sv
package ssp_pkg;
  typedef enum logic [3:0] {
    SSP_I2C_S7 = 4'h6,
    SSP_I2C_S10 = 4'h7,
    SSP_I2C_MST = 4'h8,
    SSP_SPI_MDIV = 4'ha,
    SSP_I2C_FW = 4'hb,
    SSP_I2C_S7_SS = 4'he,
    SSP_I2C_S10_SS = 4'hf
  } ssp_mode_t;
  typedef enum logic [1:0] {
    SL_IDLE = 2'b00,
    SL_ADDR = 2'b01,
    SL_RX = 2'b11,
    SL_TX = 2'b10
  } ssp_sl_t;
endpackage

// file: ssp_evt_if.sv
`timescale 1ns/1ps
interface ssp_evt_if;
  logic start;
  logic stop;
  logic scl_rise;
  logic scl_fall;
  logic fall8;
  logic rise9;
  logic ack_end;
  logic [7:0] byte_q;
  modport src (output start, stop, scl_rise, scl_fall, fall8, rise9, ack_end, byte_q);
  modport dst (input start, stop, scl_rise, scl_fall, fall8, rise9, ack_end, byte_q);
endinterface

// file: ssp_scl_watch.sv
`timescale 1ns/1ps
module ssp_scl_watch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl_i,
  input wire logic sda_i,
  ssp_evt_if.src ev
);
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_r;
  logic in_ack_r;
  logic [7:0] byte_r;
  logic rise;
  logic fall;

  assign rise = ~scl_q & scl_i;
  assign fall = scl_q & ~scl_i;
  assign ev.start = scl_q & scl_i & sda_q & ~sda_i;
  assign ev.stop = scl_q & scl_i & ~sda_q & sda_i;
  assign ev.scl_rise = rise;
  assign ev.scl_fall = fall;
  // eighth falling edge closes the byte and opens the ack slot
  assign ev.fall8 = fall & (cnt_r == 4'h8) & ~in_ack_r;
  assign ev.rise9 = rise & in_ack_r;
  assign ev.ack_end = fall & in_ack_r;
  assign ev.byte_q = byte_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 4'h0;
      in_ack_r <= 1'b0;
      byte_r <= 8'h00;
    end else if (ev.start || ev.stop) begin
      cnt_r <= 4'h0;
      in_ack_r <= 1'b0;
    end else if (rise && !in_ack_r && cnt_r < 4'h8) begin
      byte_r <= {byte_r[6:0], sda_i};
      cnt_r <= cnt_r + 4'h1;
    end else if (ev.fall8) begin
      in_ack_r <= 1'b1;
    end else if (ev.ack_end) begin
      in_ack_r <= 1'b0;
      cnt_r <= 4'h0;
    end
  end
endmodule

// file: ssp_baud_div.sv
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_baud_div #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en,
  input wire logic [W-1:0] divisor,
  output logic clk_o
);
  logic [W:0] cnt_r;
  logic [W-1:0] div_eff;
  logic [W:0] half_m1;
  logic [W+1:0] per_r;
  logic seen_r;
  logic [W-1:0] div_q_r;

  // values below the minimum are not valid and run at the minimum
  assign div_eff = (divisor < W'(`SSP_BAUD_MIN)) ? W'(`SSP_BAUD_MIN) : divisor;
  assign half_m1 = {div_eff, 1'b1};

  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      cnt_r <= '0;
      clk_o <= 1'b0;
    end else if (cnt_r == half_m1) begin
      cnt_r <= '0;
      clk_o <= ~clk_o;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // a new divisor distorts the running period, so the measurement restarts
  always_ff @(posedge aclk) begin
    if (!aresetn) div_q_r <= '0;
    else div_q_r <= divisor;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !en || divisor != div_q_r) begin
      per_r <= '0;
      seen_r <= 1'b0;
    end else if (!clk_o && cnt_r == half_m1) begin
      per_r <= '0;
      seen_r <= 1'b1;
    end else begin
      per_r <= per_r + 1'b1;
    end
  end

  chk_baud_period: assert property (@(posedge aclk) disable iff (!aresetn || !en)
    (!clk_o && cnt_r == half_m1 && seen_r && $stable(divisor)) |-> per_r == {div_eff, 2'b11})
    else $error("serial clock period wrong");
endmodule

// file: ssp_i2c_mst.sv
`timescale 1ns/1ps
module ssp_i2c_mst (
  input wire logic aclk,
  input wire logic scl_l,
  input wire logic sda_l,
  output logic scl_pull,
  output logic sda_pull
);
  localparam int H = 40;
  initial begin
    scl_pull = 0;
    sda_pull = 0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // let scl go and wait while the slave keeps it low
  task automatic hi(output logic s);
    scl_pull <= 0;
    do begin
      gap(1);
    end while (scl_l !== 1'b1);
    gap(4);
    s = sda_l;
    gap(H - 4);
    scl_pull <= 1;
    gap(H / 2);
  endtask
  task automatic start();
    sda_pull <= 1;
    gap(H);
    scl_pull <= 1;
    gap(H / 2);
  endtask
  task automatic stop();
    sda_pull <= 1;
    gap(H / 2);
    scl_pull <= 0;
    gap(H);
    sda_pull <= 0;
    gap(H);
  endtask
  // msb first, then a released ninth bit for the acknowledge
  task automatic xfer(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_pull <= ~b[i];
      gap(H / 2);
      hi(s);
    end
    sda_pull <= 0;
    gap(H / 2);
    hi(s);
    ack = (s === 1'b0);
  endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module testbench;
  import ssp_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [`SSP_AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, a2;
  logic scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, spi_rx_valid, master_clk_o, serial_irq;
  logic scl_pull, sda_pull, ack;
  logic [7:0] spi_rx_byte, b1, b2, mk, n;
  logic [6:0] a, rx;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_irq = 0;
  int seed, p;
  ssp_mode_t ml [4] = '{SSP_I2C_S7, SSP_I2C_S10, SSP_I2C_S7_SS, SSP_I2C_S10_SS};
  ssp_top ssp_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .spi_rx_valid, .spi_rx_byte,
    .master_clk_o, .serial_irq);
  ssp_i2c_mst ssp_i2c_mst_i (.aclk, .scl_l(scl_i), .sda_l(sda_i), .scl_pull, .sda_pull);
  // both lines have pull-ups
  assign scl_i = ~(scl_oe | scl_pull);
  assign sda_i = ~(sda_oe | sda_pull);
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (serial_irq === 1'b1) n_irq++;
    if (cyc == 100000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] ix, input logic [7:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= {ix, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [11:0] ix, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {ix, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic wchk(input logic [11:0] ix, input logic [7:0] v);
    wr(ix, v, rsp);
    chk("bresp", `SSP_RESP_OKAY, rsp);
  endtask
  task automatic rchk(input string nm, input logic [11:0] ix, input logic [31:0] e);
    rd(ix, d, rsp);
    chk(nm, e, d);
    chk("rresp", `SSP_RESP_OKAY, rsp);
  endtask
  task automatic spi(input logic [7:0] v);
    @(posedge aclk);
    spi_rx_valid <= 1;
    spi_rx_byte <= v;
    @(posedge aclk);
    spi_rx_valid <= 0;
    repeat (2) @(posedge aclk);
  endtask
  // rising edge to rising edge of the divider clock
  task automatic per(output int q);
    @(posedge aclk);
    while (master_clk_o !== 1'b0) @(posedge aclk);
    while (master_clk_o !== 1'b1) @(posedge aclk);
    q = 0;
    do begin
      @(posedge aclk);
      q++;
    end while (master_clk_o !== 1'b0);
    while (master_clk_o !== 1'b1) begin
      @(posedge aclk);
      q++;
    end
  endtask
  task automatic clr();
    rd(`SSP_IDX_BUF, d, rsp);
    wchk(`SSP_IDX_STAT, 8'h06);
  endtask
  // software side of an address or data hold: inspect, then release the clock
  task automatic release_hold(input logic [7:0] c3e);
    @(posedge aclk);
    while (scl_oe !== 1'b1 || ssp_i2c_mst_i.scl_pull !== 1'b0) @(posedge aclk);
    chk("scl_held", 0, scl_i);
    rchk("ack_phase", `SSP_IDX_CTL3, c3e);
    rchk("ckp_clear", `SSP_IDX_CTL1, {4'h0, SSP_I2C_S7});
    wchk(`SSP_IDX_CTL1, {4'h1, SSP_I2C_S7});
  endtask
  function automatic logic [31:0] irq_exp(input logic [3:0] m, input logic en);
    return (m[3] || (m == 4'h6 && en)) ? 2 : 0;
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    seed = 26;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, spi_rx_byte} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, spi_rx_valid} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rchk("add_rst", `SSP_IDX_ADD, `SSP_RST_ADD);
    rchk("msk_rst", `SSP_IDX_MSK, `SSP_RST_MSK);
    rchk("ctl1_rst", `SSP_IDX_CTL1, 8'h10);
    rchk("ctl3_rst", `SSP_IDX_CTL3, 8'h00);
    rd(12'h000, d, rsp);
    chk("unmapped_rresp", `SSP_RESP_SLVERR, rsp);
    wr(12'h000, 8'h5a, rsp);
    chk("unmapped_bresp", `SSP_RESP_SLVERR, rsp);
    chk("pin_levels", 0, {scl_o, sda_o});
    $display("test registers done");
    wchk(`SSP_IDX_CTL1, 8'h10);
    for (int o = 0; o < 2; o++) begin
      b1 = 8'($random(seed));
      b2 = 8'($random(seed));
      wchk(`SSP_IDX_CTL3, {3'b0, o[0], 4'h0});
      spi(b1);
      spi(b2);
      rchk("ov_bf", `SSP_IDX_STAT, 8'h03);
      rchk("spi_buf", `SSP_IDX_BUF, o ? b2 : b1);
      wchk(`SSP_IDX_STAT, 8'h02);
    end
    $display("test spi overwrite done");
    for (int k = 0; k < 6; k++) begin
      n = k[1] ? 8'(3 + {$random(seed)} % 253) : (k[0] ? 8'hff : 8'h03);
      wchk(`SSP_IDX_ADD, n);
      wchk(`SSP_IDX_CTL1, {4'h1, k < 3 ? SSP_SPI_MDIV : SSP_I2C_MST});
      per(p);
      chk("clk_period", (n + 1) * 4, p);
    end
    $display("test divider done");
    foreach (ml[k]) begin
      for (int en = 0; en < 2; en++) begin
        wchk(`SSP_IDX_CTL1, {4'h1, ml[k]});
        wchk(`SSP_IDX_CTL3, {1'b0, en[0], en[0], 5'h08});
        n_irq = 0;
        ssp_i2c_mst_i.start();
        ssp_i2c_mst_i.stop();
        chk("irq_count", irq_exp(ml[k], en[0]), n_irq);
      end
    end
    $display("test start stop interrupt done");
    wchk(`SSP_IDX_CTL1, {4'h1, SSP_I2C_S7});
    for (int k = 0; k < 6; k++) begin
      a = 7'($random(seed));
      mk = k ? 8'($random(seed)) : 8'hff;
      rx = k[0] ? 7'($random(seed)) : a;
      wchk(`SSP_IDX_ADD, {a, k[1]});
      wchk(`SSP_IDX_MSK, mk);
      wchk(`SSP_IDX_CTL3, {4'h0, ~k[0], 1'b0, k == 0, k == 2});
      ssp_i2c_mst_i.start();
      fork
        ssp_i2c_mst_i.xfer({rx, 1'b0}, ack);
        if (k == 0) release_hold(8'h8a);
      join
      chk("addr_ack", ((rx ^ a) & mk[7:1]) == 0, ack);
      // two data bytes under data hold; the second meets a set overflow
      for (int j = 0; j < 2 && k == 2; j++) begin
        b1 = 8'($random(seed));
        fork
          ssp_i2c_mst_i.xfer(b1, ack);
          release_hold(8'h89);
        join
        chk("data_ack", 1, ack);
        if (j == 0) b2 = b1;
      end
      if (k == 2) rchk("i2c_ov", `SSP_IDX_STAT, 8'h03);
      if (k == 2) rchk("i2c_buf", `SSP_IDX_BUF, b2);
      ssp_i2c_mst_i.stop();
      clr();
    end
    wchk(`SSP_IDX_CTL1, {4'h1, SSP_I2C_S10});
    wchk(`SSP_IDX_MSK, 8'hff);
    for (int k = 0; k < 2; k++) begin
      a2 = 2'($random(seed));
      wchk(`SSP_IDX_ADD, {5'h1f, a2, 1'b1});
      ssp_i2c_mst_i.start();
      ssp_i2c_mst_i.xfer({`SSP_TEN_HDR, a2 ^ {1'b0, k[0]}, 1'b0}, ack);
      chk("ten_hi_ack", k == 0, ack);
      ssp_i2c_mst_i.stop();
      clr();
    end
    $display("test address match done");
    finish_test();
  end
endmodule
